// ==== src/pfch_map.vh ====
`ifndef PFCH_MAP_VH
`define PFCH_MAP_VH

// function codes carried in the byte after the transaction number
`define PFCH_FNC_WRNG_WR 8'h00
`define PFCH_FNC_WRNG_RD 8'h01
`define PFCH_FNC_FILE_WR 8'h03
`define PFCH_FNC_FILE_RD 8'h04
`define PFCH_FNC_DL_REQ 8'h05
`define PFCH_FNC_UL_REQ 8'h06
`define PFCH_FNC_SHUTDN 8'h07
`define PFCH_FNC_PHYS_WR 8'h08
`define PFCH_FNC_PHYS_RD 8'h09
`define PFCH_FNC_RESTART 8'h0A

// byte positions of the fixed command header
`define PFCH_POS_DST 4'h0
`define PFCH_POS_SRC 4'h1
`define PFCH_POS_CMD 4'h2
`define PFCH_POS_TNS_LO 4'h4
`define PFCH_POS_TNS_HI 4'h5
`define PFCH_POS_FNC 4'h6
`define PFCH_POS_PARAM 4'h7

// parameter slots after the function code
`define PFCH_PRM_WF 2'h0
`define PFCH_PRM_ADDR_LO 2'h1
`define PFCH_PRM_ADDR_HI 2'h2
`define PFCH_PRM_SIZE 2'h3

// reply fields
`define PFCH_REPLY_BIT 8'h40
`define PFCH_STS_OK 8'h00
`define PFCH_STS_EXT 8'hF0
`define PFCH_REPLY_EXT_POS 3'h6
`define PFCH_REPLY_HDR_LAST 3'h5

// extended status codes, zero means success
`define PFCH_EXT_NONE 8'h00
`define PFCH_EXT_BAD_FNC 8'h01
`define PFCH_EXT_PRIV 8'h02
`define PFCH_EXT_SEQ 8'h03
`define PFCH_EXT_ADDR 8'h04
`define PFCH_EXT_SIZE 8'h05
`define PFCH_EXT_FORMAT 8'h06

// read limit per reply packet, bytes
`define PFCH_MAX_READ 8'hF4

// privilege kinds
`define PFCH_PRIV_NONE 2'h0
`define PFCH_PRIV_UP 2'h1
`define PFCH_PRIV_DN 2'h2

// memory space selects
`define PFCH_SPACE_WORD 2'h0
`define PFCH_SPACE_FILE 2'h1
`define PFCH_SPACE_PHYS 2'h2

// reply buffer shape
`define PFCH_FIFO_WIDTH 9
`define PFCH_FIFO_DEPTH 4

`endif

// ==== src/pfch_fifo.v ====
`timescale 1ns/1ns
module pfch_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // drain side
  output reg out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  // head sits in slot 0 so the drain side reads a flip-flop directly
  reg [WIDTH-1:0] slot [0:DEPTH-1];
  reg [3:0] count;
  wire push;
  wire pop;
  reg [3:0] next_count;
  integer i;

  assign in_ready = (count != DEPTH[3:0]);
  assign out_data = slot[0];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 4'h1;
    else if (pop & ~push)
      next_count = count - 4'h1;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
      out_valid <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
        slot[i] <= {WIDTH{1'b0}};
    end else begin
      count <= next_count;
      out_valid <= (next_count != 4'h0);
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (pop && i < DEPTH - 1)
          slot[i] <= slot[i+1];
        if (push && i == (pop ? count - 4'h1 : count))
          slot[i] <= in_data;
      end
    end
  end
endmodule // pfch_fifo

// ==== src/pfch_main.v ====
`timescale 1ns/1ns
`include "pfch_map.vh"
// Notes on behaviour
// - function 4 reads a file of words
// - function 3 writes a file of words
// - read reply carries data, 244 bytes max
// - error reply ends in optional extended status
// - function 9 reads physical memory for upload
// - physical access only after own shutdown
// - function 8 writes physical memory for download
// - restart 10 revokes privileges, restarts controller
// - shutdown 7: download halts, upload freezes
// - upload 6 denied if another holds upload
// - function 1 reads a word range
// - function 0 writes a word range
// - word address must fall inside a file
// - download 5 denied if another holds download
// - extended status only with status F0
// - word/file flag zero means word symbol
module pfch_main (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // command byte stream from the link
  input wire cmd_valid,
  input wire [7:0] cmd_data,
  input wire cmd_last,
  output reg cmd_ready,
  // reply byte stream to the link
  output wire rep_valid,
  output wire [7:0] rep_data,
  output wire rep_last,
  input wire rep_ready,
  // controller memory access
  output reg mem_req,
  output reg mem_we,
  output reg [1:0] mem_space,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  input wire mem_err,
  // controller control pulses and privilege state
  output reg ctl_shutdown,
  output reg ctl_freeze,
  output reg ctl_restart,
  output reg [1:0] priv_held,
  output reg [7:0] priv_station
);
  localparam S_HDR = 3'h0;
  localparam S_EXEC = 3'h1;
  localparam S_DRAIN = 3'h2;
  localparam S_WR = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_RWAIT = 3'h5;
  localparam S_TX = 3'h6;
  localparam S_RDATA = 3'h7;

  reg [2:0] state;
  reg [3:0] idx;
  reg [7:0] dst;
  reg [7:0] src;
  reg [7:0] cmd;
  reg [7:0] tns_lo;
  reg [7:0] tns_hi;
  reg [7:0] function_code;
  reg [7:0] wf;
  reg [15:0] addr;
  reg [7:0] size;
  reg [7:0] ext;
  reg [7:0] cnt;
  reg [7:0] rbyte;
  reg got_last;
  reg rd_mode;
  reg shut_done;
  reg [7:0] tx_byte;
  reg tx_last;
  wire push_valid;
  wire push_ready;
  wire [3:0] pidx;
  wire [1:0] slot;
  wire hdr_done;
  wire owner;
  wire reading;

  // parameter bytes that follow the function code
  function [3:0] nparam;
    input [7:0] f;
    begin
      case (f)
        `PFCH_FNC_WRNG_WR, `PFCH_FNC_FILE_WR: nparam = 4'h3;
        `PFCH_FNC_WRNG_RD, `PFCH_FNC_FILE_RD: nparam = 4'h4;
        `PFCH_FNC_PHYS_WR: nparam = 4'h2;
        `PFCH_FNC_PHYS_RD: nparam = 4'h3;
        default: nparam = 4'h0;
      endcase
    end
  endfunction

  function is_phys;
    input [7:0] f;
    begin
      is_phys = (f == `PFCH_FNC_PHYS_WR) || (f == `PFCH_FNC_PHYS_RD);
    end
  endfunction

  // physical commands have no word/file flag, so their slots shift by one
  assign pidx = idx - `PFCH_POS_PARAM;
  assign slot = is_phys(function_code) ? pidx[1:0] + 2'h1 : pidx[1:0];
  assign hdr_done = (idx == `PFCH_POS_FNC) ? (nparam(cmd_data) == 4'h0) :
                    ((idx > `PFCH_POS_FNC) && (pidx == nparam(function_code) - 4'h1));
  assign owner = (priv_held != `PFCH_PRIV_NONE) && (priv_station == src);
  assign reading = rd_mode && (ext == `PFCH_EXT_NONE);

  // reply byte selection
  always @* begin
    tx_byte = rbyte;
    tx_last = (cnt == 8'h01);
    if (state == S_TX) begin
      tx_last = (idx[2:0] == `PFCH_REPLY_EXT_POS) ||
                ((idx[2:0] == `PFCH_REPLY_HDR_LAST) && !rd_mode &&
                 (ext == `PFCH_EXT_NONE));
      case (idx[2:0])
        3'h0: tx_byte = src;
        3'h1: tx_byte = dst;
        3'h2: tx_byte = cmd | `PFCH_REPLY_BIT;
        3'h3: tx_byte = (ext != `PFCH_EXT_NONE) ? `PFCH_STS_EXT : `PFCH_STS_OK;
        3'h4: tx_byte = tns_lo;
        3'h5: tx_byte = tns_hi;
        default: tx_byte = ext;
      endcase
    end
  end

  assign push_valid = (state == S_TX) || (state == S_RDATA);

  // reply buffer back-pressure stalls transmit and read states
  pfch_fifo #(
    .WIDTH(`PFCH_FIFO_WIDTH),
    .DEPTH(`PFCH_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_data({tx_last, tx_byte}),
    .in_ready(push_ready),
    .out_valid(rep_valid),
    .out_data({rep_last, rep_data}),
    .out_ready(rep_ready)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_HDR;
      idx <= 4'h0;
      cmd_ready <= 1'b1;
      dst <= 8'h00;
      src <= 8'h00;
      cmd <= 8'h00;
      tns_lo <= 8'h00;
      tns_hi <= 8'h00;
      function_code <= 8'h00;
      wf <= 8'h00;
      addr <= 16'h0000;
      size <= 8'h00;
      ext <= `PFCH_EXT_NONE;
      cnt <= 8'h00;
      rbyte <= 8'h00;
      got_last <= 1'b0;
      rd_mode <= 1'b0;
      shut_done <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_space <= `PFCH_SPACE_WORD;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      ctl_shutdown <= 1'b0;
      ctl_freeze <= 1'b0;
      ctl_restart <= 1'b0;
      priv_held <= `PFCH_PRIV_NONE;
      priv_station <= 8'h00;
    end else begin
      mem_req <= 1'b0;
      ctl_shutdown <= 1'b0;
      ctl_freeze <= 1'b0;
      ctl_restart <= 1'b0;
      case (state)
        S_HDR: begin
          if (cmd_valid) begin
            idx <= idx + 4'h1;
            case (idx)
              `PFCH_POS_DST: dst <= cmd_data;
              `PFCH_POS_SRC: src <= cmd_data;
              `PFCH_POS_CMD: cmd <= cmd_data;
              `PFCH_POS_TNS_LO: tns_lo <= cmd_data;
              `PFCH_POS_TNS_HI: tns_hi <= cmd_data;
              `PFCH_POS_FNC: function_code <= cmd_data;
              default: begin
                case (slot)
                  `PFCH_PRM_WF: wf <= cmd_data;
                  `PFCH_PRM_ADDR_LO: addr[7:0] <= cmd_data;
                  `PFCH_PRM_ADDR_HI: addr[15:8] <= cmd_data;
                  default: size <= cmd_data;
                endcase
              end
            endcase
            if (idx == `PFCH_POS_DST) begin
              ext <= `PFCH_EXT_NONE;
              rd_mode <= 1'b0;
              wf <= 8'h00;
              size <= 8'h00;
            end
            if (hdr_done || cmd_last) begin
              got_last <= cmd_last;
              cmd_ready <= 1'b0;
              state <= S_EXEC;
              if (!hdr_done)
                ext <= `PFCH_EXT_FORMAT;
            end
          end
        end
        S_EXEC: begin
          idx <= 4'h0;
          mem_addr <= addr;
          mem_space <= is_phys(function_code) ? `PFCH_SPACE_PHYS :
                       ((wf != 8'h00) ? `PFCH_SPACE_FILE : `PFCH_SPACE_WORD);
          mem_we <= 1'b0;
          cnt <= size;
          if (ext == `PFCH_EXT_NONE) begin
            case (function_code)
              `PFCH_FNC_WRNG_RD, `PFCH_FNC_FILE_RD, `PFCH_FNC_PHYS_RD: begin
                if (function_code == `PFCH_FNC_FILE_RD && wf == 8'h00)
                  ext <= `PFCH_EXT_ADDR;
                else if (function_code == `PFCH_FNC_PHYS_RD && !(owner && shut_done))
                  ext <= `PFCH_EXT_SEQ;
                else if (size == 8'h00 || size > `PFCH_MAX_READ)
                  ext <= `PFCH_EXT_SIZE;
                else
                  rd_mode <= 1'b1;
              end
              `PFCH_FNC_WRNG_WR, `PFCH_FNC_FILE_WR, `PFCH_FNC_PHYS_WR: begin
                if (function_code == `PFCH_FNC_FILE_WR && wf == 8'h00)
                  ext <= `PFCH_EXT_ADDR;
                else if (function_code == `PFCH_FNC_PHYS_WR && !(owner && shut_done))
                  ext <= `PFCH_EXT_SEQ;
                else if (got_last)
                  ext <= `PFCH_EXT_FORMAT;
              end
              `PFCH_FNC_DL_REQ, `PFCH_FNC_UL_REQ: begin
                // one holder at a time; a second station is denied
                if (priv_held != `PFCH_PRIV_NONE && priv_station != src)
                  ext <= `PFCH_EXT_PRIV;
                else begin
                  priv_station <= src;
                  shut_done <= 1'b0;
                  priv_held <= (function_code == `PFCH_FNC_DL_REQ) ? `PFCH_PRIV_DN :
                               `PFCH_PRIV_UP;
                end
              end
              `PFCH_FNC_SHUTDN: begin
                if (!owner)
                  ext <= `PFCH_EXT_SEQ;
                else begin
                  shut_done <= 1'b1;
                  ctl_shutdown <= (priv_held == `PFCH_PRIV_DN);
                  ctl_freeze <= (priv_held == `PFCH_PRIV_UP);
                end
              end
              `PFCH_FNC_RESTART: begin
                if (!(owner && shut_done))
                  ext <= `PFCH_EXT_SEQ;
                else begin
                  priv_held <= `PFCH_PRIV_NONE;
                  shut_done <= 1'b0;
                  ctl_restart <= 1'b1;
                end
              end
              default: ext <= `PFCH_EXT_BAD_FNC;
            endcase
            // write data is taken after the header on every write command that did not end there
            if ((function_code == `PFCH_FNC_WRNG_WR || function_code == `PFCH_FNC_FILE_WR ||
                 function_code == `PFCH_FNC_PHYS_WR) && !got_last) begin
              state <= S_WR;
              cmd_ready <= 1'b1;
            end else if (!got_last) begin
              state <= S_DRAIN;
              cmd_ready <= 1'b1;
            end else if ((function_code == `PFCH_FNC_WRNG_RD || function_code == `PFCH_FNC_FILE_RD ||
                          function_code == `PFCH_FNC_PHYS_RD) && size != 8'h00 &&
                         size <= `PFCH_MAX_READ &&
                         !(function_code == `PFCH_FNC_FILE_RD && wf == 8'h00) &&
                         !(function_code == `PFCH_FNC_PHYS_RD && !(owner && shut_done))) begin
              mem_req <= 1'b1;
              state <= S_RWAIT;
            end else
              state <= S_TX;
          end else if (!got_last) begin
            state <= S_DRAIN;
            cmd_ready <= 1'b1;
          end else
            state <= S_TX;
        end
        S_DRAIN: begin
          // stray bytes are discarded so the next packet starts aligned
          if (cmd_valid && cmd_last) begin
            cmd_ready <= 1'b0;
            if (reading) begin
              mem_req <= 1'b1;
              state <= S_RWAIT;
            end else
              state <= S_TX;
          end
        end
        S_WR: begin
          if (cmd_valid) begin
            got_last <= cmd_last;
            cmd_ready <= 1'b0;
            if (ext == `PFCH_EXT_NONE) begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_wdata <= cmd_data;
              state <= S_WACK;
            end else if (cmd_last)
              state <= S_TX;
            else
              cmd_ready <= 1'b1;
          end
        end
        S_WACK: begin
          if (mem_ack) begin
            mem_we <= 1'b0;
            mem_addr <= mem_addr + 16'h0001;
            if (mem_err)
              ext <= `PFCH_EXT_ADDR;
            if (got_last)
              state <= S_TX;
            else begin
              state <= S_WR;
              cmd_ready <= 1'b1;
            end
          end
        end
        S_RWAIT: begin
          if (mem_ack) begin
            rbyte <= mem_rdata;
            mem_addr <= mem_addr + 16'h0001;
            if (idx == 4'h0) begin
              // only the first byte can still turn into an error reply
              if (mem_err) begin
                ext <= `PFCH_EXT_ADDR;
                rd_mode <= 1'b0;
              end
              state <= S_TX;
            end else
              state <= S_RDATA;
          end
        end
        S_TX: begin
          if (push_ready) begin
            idx <= idx + 4'h1;
            if (tx_last) begin
              idx <= 4'h0;
              state <= S_HDR;
              cmd_ready <= 1'b1;
            end else if (idx[2:0] == `PFCH_REPLY_HDR_LAST && reading) begin
              idx <= 4'h8;
              state <= S_RDATA;
            end
          end
        end
        S_RDATA: begin
          if (push_ready) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
              idx <= 4'h0;
              rd_mode <= 1'b0;
              state <= S_HDR;
              cmd_ready <= 1'b1;
            end else begin
              mem_req <= 1'b1;
              state <= S_RWAIT;
            end
          end
        end
        default: begin
          state <= S_HDR;
          idx <= 4'h0;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule // pfch_main

// ==== tb/pfch_mem_model.sv ====
`timescale 1ns/1ns
module pfch_mem_model #(
  parameter LAT = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  output logic mem_err
);
  logic [7:0] mem [0:255];
  int wait_cnt;
  logic bad;
  // the top nibble marks space outside any file
  assign bad = (mem_addr[15:12] == 4'hF);
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end
  // odd addresses answer promptly, even ones slowly
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 0;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= 8'h00;
    end else if (mem_req) begin
      wait_cnt <= mem_addr[0] ? 1 : LAT;
      mem_ack <= 1'b0;
    end else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      mem_ack <= 1'b1;
      mem_err <= bad;
      mem_rdata <= mem[mem_addr[7:0]];
      if (mem_we && !bad) begin
        mem[mem_addr[7:0]] <= mem_wdata;
      end
    end else begin
      wait_cnt <= (wait_cnt > 1) ? wait_cnt - 1 : 0;
      mem_ack <= 1'b0;
      mem_err <= ~mem_err;
      // stale data is not held once the answer has been given
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // pfch_mem_model

// ==== tb/pfch_main_checker.sv ====
`timescale 1ns/1ns
`include "pfch_map.vh"
module pfch_main_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reply stream
  input wire logic rep_valid,
  input wire logic [7:0] rep_data,
  input wire logic rep_last,
  input wire logic rep_ready,
  // memory and control
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic mem_we,
  input wire logic [1:0] mem_space,
  input wire logic [15:0] mem_addr,
  input wire logic ctl_shutdown,
  input wire logic ctl_freeze,
  input wire logic ctl_restart,
  input wire logic [1:0] priv_held
);
  logic [7:0] idx;
  logic [7:0] sts;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 8'h00;
      sts <= 8'h00;
    end else if (rep_valid && rep_ready) begin
      idx <= rep_last ? 8'h00 : idx + 8'h01;
      if (idx == 8'h03) begin
        sts <= rep_data;
      end
    end
  end
  a_reply_flag: assert property (rep_valid && idx == 8'h02 |-> rep_data[6])
    else $error("reply command lacks reply bit");
  a_status_code: assert property (rep_valid && idx == 8'h03 |->
    rep_data == `PFCH_STS_OK || rep_data == `PFCH_STS_EXT)
    else $error("reply status not 00 or F0");
  a_header_whole: assert property (rep_valid && idx < 8'h05 |-> !rep_last)
    else $error("reply ended inside header");
  a_ext_ends: assert property (rep_valid && idx == 8'h06 && sts == `PFCH_STS_EXT |->
    rep_last)
    else $error("error reply longer than extended status");
  a_read_limit: assert property (rep_valid |-> idx <= 8'hF9)
    else $error("reply longer than 244 data bytes");
  a_freeze_upload: assert property (ctl_freeze |-> priv_held == `PFCH_PRIV_UP)
    else $error("freeze without upload privilege");
  a_halt_download: assert property (ctl_shutdown |->
    priv_held == `PFCH_PRIV_DN ##1 !ctl_shutdown)
    else $error("shutdown without download privilege");
  a_restart_revoke: assert property (ctl_restart |-> ##[0:2]
    priv_held == `PFCH_PRIV_NONE)
    else $error("restart left privilege in place");
  a_phys_holder: assert property (mem_req && mem_space == `PFCH_SPACE_PHYS |->
    priv_held != `PFCH_PRIV_NONE)
    else $error("physical access without privilege");
  a_mem_hold: assert property (mem_req ##1 !mem_ack |->
    $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
endmodule // pfch_main_checker
bind pfch_main pfch_main_checker u_chk (.clk(clk), .rst_n(rst_n), .rep_valid(rep_valid),
  .rep_data(rep_data), .rep_last(rep_last), .rep_ready(rep_ready), .mem_req(mem_req),
  .mem_ack(mem_ack), .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
  .ctl_shutdown(ctl_shutdown), .ctl_freeze(ctl_freeze), .ctl_restart(ctl_restart),
  .priv_held(priv_held));

// ==== tb/test_pfch_main.sv ====
`timescale 1ns/1ns
`include "pfch_map.vh"
module test_pfch_main;
  localparam logic [7:0] DEV = 8'h10;
  localparam logic [7:0] STA = 8'h21;
  localparam logic [7:0] STB = 8'h32;
  logic clk, rst_n, cmd_valid, cmd_last, cmd_ready, rep_valid, rep_last;
  logic rep_ready = 1'b0;
  logic [7:0] cmd_data, rep_data, mem_wdata, mem_rdata, priv_station, transaction_number;
  logic mem_req, mem_we, mem_ack, mem_err, ctl_shutdown, ctl_freeze, ctl_restart;
  logic [1:0] mem_space, priv_held;
  logic [15:0] mem_addr;
  logic stall, got_last;
  logic [1:0] sp;
  logic [7:0] pkt [0:15];
  logic [7:0] rq [$];
  int error_cnt, checks_done, cyc, plen, n_frz, n_shd, n_rst;
  pfch_main u_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rep_valid(rep_valid), .rep_data(rep_data),
    .rep_last(rep_last), .rep_ready(rep_ready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
    .ctl_shutdown(ctl_shutdown), .ctl_freeze(ctl_freeze), .ctl_restart(ctl_restart),
    .priv_held(priv_held), .priv_station(priv_station));
  pfch_mem_model u_mem (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .mem_err(mem_err));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rep_valid === 1'b1 && rep_ready === 1'b1) begin
      rq.push_back(rep_data);
      got_last = rep_last;
    end
    n_frz += (ctl_freeze === 1'b1);
    n_shd += (ctl_shutdown === 1'b1);
    n_rst += (ctl_restart === 1'b1);
    if (mem_req === 1'b1) sp = mem_space;
  end
  // the consumer skips every fourth cycle so the buffer sees back-pressure
  always @(negedge clk) begin
    cyc++;
    rep_ready <= !stall && (cyc % 4 != 3);
    if (cyc > 60000) begin
      error_cnt++;
      conclude();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task hdr(input logic [7:0] src, input logic [7:0] function_code);
    transaction_number = transaction_number + 8'h01;
    pkt[0] = DEV; pkt[1] = src; pkt[2] = 8'h0F; pkt[3] = 8'h00;
    pkt[4] = transaction_number; pkt[5] = ~transaction_number; pkt[6] = function_code;
    plen = 7;
  endtask
  task add(input logic [7:0] b);
    pkt[plen] = b;
    plen++;
  endtask
  // sends the packet, then collects one reply and checks its header
  task run(input logic [7:0] sts, input int n);
    rq.delete();
    got_last = 1'b0;
    for (int i = 0; i < plen; i++) begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_data = pkt[i];
      cmd_last = (i == plen - 1);
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_last = 1'b0;
    for (int k = 0; k < 2000 && !got_last; k++) begin
      if (k == 40) stall = 1'b0;
      @(posedge clk);
    end
    @(negedge clk);
    chk(got_last, 1'b1, "reply end");
    chk(rq.size(), (sts == `PFCH_STS_EXT) ? 7 : 6 + n, "reply length");
    chk(rq[0], pkt[1], "reply dest");
    chk(rq[1], DEV, "reply source");
    chk(rq[2], 8'h4F, "reply command");
    chk(rq[3], sts, "reply status");
    chk({rq[5], rq[4]}, {pkt[5], pkt[4]}, "reply transaction");
  endtask
  task t_word;
    hdr(STA, `PFCH_FNC_WRNG_RD); add(8'h00); add(8'h40); add(8'h00); add(8'h02);
    run(`PFCH_STS_OK, 2);
    chk({rq[6], rq[7]}, {8'h40 ^ 8'h5A, 8'h41 ^ 8'h5A}, "word read data");
    chk(sp, `PFCH_SPACE_WORD, "word space");
    hdr(STA, `PFCH_FNC_WRNG_WR); add(8'h00); add(8'h50); add(8'h00); add(8'hC3); add(8'h3C);
    run(`PFCH_STS_OK, 0);
    chk({u_mem.mem[8'h50], u_mem.mem[8'h51]}, 16'hC33C, "word write data");
    hdr(STA, `PFCH_FNC_WRNG_RD); add(8'h00); add(8'h00); add(8'hF0); add(8'h02);
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_ADDR, "word outside file");
    hdr(STA, `PFCH_FNC_WRNG_WR);
    add(8'h00);
    add(8'h00);
    add(8'hF0);
    add(8'h11);
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_ADDR, "write outside file");
    hdr(STA, `PFCH_FNC_WRNG_WR);
    add(8'h00);
    add(8'h50);
    add(8'h00);
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_FORMAT, "write without data");
    chk(u_mem.mem[8'h50], 8'hC3, "no write without data");
    hdr(STA, `PFCH_FNC_WRNG_RD);
    add(8'h00);
    add(8'h42);
    add(8'h00);
    add(8'h02);
    add(8'h99);
    run(`PFCH_STS_OK, 2);
    chk({rq[6], rq[7]}, {8'h42 ^ 8'h5A, 8'h43 ^ 8'h5A}, "read with trailing byte");
    $display("test word range done");
  endtask
  task t_file;
    hdr(STA, `PFCH_FNC_FILE_WR); add(8'h01); add(8'h60); add(8'h00); add(8'hAA); add(8'h55);
    run(`PFCH_STS_OK, 0);
    hdr(STA, `PFCH_FNC_FILE_RD); add(8'h01); add(8'h60); add(8'h00); add(8'h02);
    run(`PFCH_STS_OK, 2);
    chk({rq[6], rq[7]}, 16'hAA55, "file read data");
    chk(sp, `PFCH_SPACE_FILE, "file space");
    hdr(STA, `PFCH_FNC_FILE_RD); add(8'h00); add(8'h60); add(8'h00); add(8'h02);
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_ADDR, "word flag on file read");
    $display("test file done");
  endtask
  task t_size;
    stall = 1'b1;
    hdr(STA, `PFCH_FNC_WRNG_RD); add(8'h00); add(8'h00); add(8'h00); add(8'hF4);
    run(`PFCH_STS_OK, 244);
    chk(rq[249], 8'hF3 ^ 8'h5A, "last of 244 bytes");
    pkt[10] = 8'hF5;
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_SIZE, "size above limit");
    $display("test size done");
  endtask
  task t_priv;
    hdr(STA, `PFCH_FNC_PHYS_RD); add(8'h10); add(8'h00); add(8'h04);
    run(`PFCH_STS_EXT, 0);
    hdr(STA, `PFCH_FNC_SHUTDN);
    run(`PFCH_STS_EXT, 0);
    hdr(STA, `PFCH_FNC_UL_REQ);
    run(`PFCH_STS_OK, 0);
    chk({priv_held, priv_station}, {`PFCH_PRIV_UP, STA}, "upload holder");
    hdr(STB, `PFCH_FNC_UL_REQ);
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_PRIV, "second upload");
    hdr(STA, `PFCH_FNC_PHYS_RD); add(8'h10); add(8'h00); add(8'h04);
    run(`PFCH_STS_EXT, 0);
    hdr(STA, `PFCH_FNC_SHUTDN);
    run(`PFCH_STS_OK, 0);
    chk(n_frz, 1, "freeze pulse");
    hdr(STA, `PFCH_FNC_PHYS_RD); add(8'h10); add(8'h00); add(8'h04);
    run(`PFCH_STS_OK, 4);
    chk({rq[6], rq[9]}, {8'h4A, 8'h49}, "physical read data");
    chk(sp, `PFCH_SPACE_PHYS, "physical space");
    pkt[1] = STB;
    run(`PFCH_STS_EXT, 0);
    hdr(STA, `PFCH_FNC_RESTART);
    run(`PFCH_STS_OK, 0);
    chk({n_rst[1:0], priv_held}, {2'h1, `PFCH_PRIV_NONE}, "restart revokes");
    hdr(STB, `PFCH_FNC_DL_REQ);
    run(`PFCH_STS_OK, 0);
    hdr(STA, `PFCH_FNC_DL_REQ);
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_PRIV, "second download");
    hdr(STB, `PFCH_FNC_SHUTDN);
    run(`PFCH_STS_OK, 0);
    chk(n_shd, 1, "shutdown pulse");
    hdr(STB, `PFCH_FNC_PHYS_WR); add(8'h20); add(8'h00); add(8'h77);
    run(`PFCH_STS_OK, 0);
    chk(u_mem.mem[8'h20], 8'h77, "physical write data");
    hdr(STB, 8'h0B);
    run(`PFCH_STS_EXT, 0);
    chk(rq[6], `PFCH_EXT_BAD_FNC, "unknown function");
    $display("test privilege done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    stall = 1'b0;
    transaction_number = 8'h00;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_word;
    t_file;
    t_size;
    t_priv;
    conclude;
  end
endmodule // test_pfch_main
